// File: design/pvc_regs.vh
// Register offsets, field positions, reset values and timing figures of the process value conditioning block.
`ifndef PVC_REGS_VH
`define PVC_REGS_VH
// Each channel owns a 64-byte window; the channel number is paddr[7:6].
`define PVC_OFF_CFG 6'h00
`define PVC_OFF_PAR_FIRST 6'h04
`define PVC_OFF_PAR_LAST 6'h2C
`define PVC_OFF_PV 6'h30
`define PVC_OFF_RATE 6'h34
`define PVC_OFF_STATUS 6'h38
// Parameter word indices inside a channel (offset / 4 - 1).
`define PVC_P_SMAX 4'h0
`define PVC_P_SMIN 4'h1
`define PVC_P_ZERO 4'h2
`define PVC_P_SPAN 4'h3
`define PVC_P_HYS 4'h8
`define PVC_P_AL0 4'h4
`define PVC_P_RATE_H 4'h9
// Configuration word fields.
`define PVC_CFG_RANGE 2:0
`define PVC_CFG_SQRT 3
`define PVC_CFG_NAVG 7:4
`define PVC_CFG_RIVL 11:8
`define PVC_CFG_DLY 17:12
// Input ranges.
`define PVC_RNG_4_20MA 3'h0
`define PVC_RNG_1_5V 3'h1
`define PVC_RNG_BIP10V 3'h5
// Reset values.
`define PVC_RST_CFG 18'h00000
`define PVC_RST_SMAX 16'h2710
`define PVC_RST_SPAN 16'h1000
// Samples are signed hundredths of a percent of span: 10000 is 100 %.
`define PVC_ERR_LO (-17'sd1720)
`define PVC_ERR_HI 17'sd11250
`define PVC_BREAK_PV 16'hFA24
`define PVC_OVR_PV 16'h2CEC
`define PVC_MID_PV 16'h1388
`define PVC_DROPOUT_PCT 48'sd7
`define PVC_RECIP_SPAN 33'h00068DB9
`define PVC_MAX_DLY_S 6'h3C
// Timing.
`define PVC_CLK_HZ 125000000
`define PVC_BREAK_MS 1000
`endif

// File: design/pvc_fifo.v
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module pvc_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Read side sees the oldest word whenever one is held.
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rp_r];

   // Storage has no reset; only the pointers, the count and ready need a defined state.
   always @(posedge pclk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Ready is registered from the next count so a full FIFO stalls the source.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
         in_ready <= ((cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop}) != DEPTH[AW:0]);
      end
   end
endmodule // pvc_fifo

// File: design/pvc_top.v
// Four-channel process value conditioning: checks, averaging, scaling, square root, alarms, APB registers.
// How it works
// R1: Live-zero ranges flag input error below -17.2% or above 112.5% span.
// R2: Broken wire on live-zero range stores -15% of span.
// R3: Broken wire on other ranges stores the zero-volt or zero-current value.
// R4: A broken wire reads as overrange for about one second first.
// R5: Process value is moving average of last N samples, N from 1 to 16.
// R6: Four level alarms with separate flags and hysteresis on release.
// R7: An alarm sets only after its condition held for the 0-60 s delay.
// R8: Rate alarms high and low share hysteresis and delay with level alarms.
// R9: Square root output is B plus root of (A-B) times (input-B).
// R10: Below about 7% of span the square root stage passes input linearly.
// R11: All four channels convert within 100 ms; host reads after one scan.
// R12: Order is average, scale, zero/span, square root, limit to 16 bits.
// R13: Rate is change of process value over a 1 to 16 s interval.
// R14: Square root only applies when scaling maximum exceeds minimum.
// R15: Changing the averaging count restarts that channel's window.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pvc_regs.vh"
module pvc_top #(
   parameter SEC_CYC = `PVC_CLK_HZ,
   parameter BREAK_CYC = `PVC_CLK_HZ / 1000 * `PVC_BREAK_MS
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_r,
   output reg pready_r,
   output reg pslverr_r,
   input wire samp_valid,
   output wire samp_ready,
   input wire [1:0] samp_ch,
   input wire [15:0] samp_data,
   input wire [3:0] wire_break,
   output reg out_valid_r,
   output reg [1:0] out_ch_r,
   output reg [15:0] out_pv_r,
   output reg [15:0] out_rate_r,
   output reg [5:0] out_alarm_r,
   output reg out_err_r
);
   localparam S_IDLE = 6'h01;
   localparam S_AVG = 6'h02;
   localparam S_SCALE = 6'h04;
   localparam S_ROOT = 6'h08;
   localparam S_ALARM = 6'h10;
   localparam S_OUT = 6'h20;

   // Address class: 0 cfg, 1 parameter, 2 pv, 3 rate, 4 status, 7 unmapped.
   function [2:0] pvc_dec;
      input [11:0] a;
      begin
         if (a[11:8] != 4'h0 || a[1:0] != 2'b00) pvc_dec = 3'd7;
         else if (a[5:0] == `PVC_OFF_CFG) pvc_dec = 3'd0;
         else if (a[5:0] >= `PVC_OFF_PAR_FIRST && a[5:0] <= `PVC_OFF_PAR_LAST) pvc_dec = 3'd1;
         else if (a[5:0] == `PVC_OFF_PV) pvc_dec = 3'd2;
         else if (a[5:0] == `PVC_OFF_RATE) pvc_dec = 3'd3;
         else if (a[5:0] == `PVC_OFF_STATUS) pvc_dec = 3'd4;
         else pvc_dec = 3'd7;
      end
   endfunction

   // Reciprocal of the window length in 1/65536 units avoids a divider.
   function [17:0] pvc_recip;
      input [4:0] n;
      begin
         pvc_recip = (n == 5'd0) ? 18'h10000 : 18'h10000 / n;
      end
   endfunction

   // Output limit to the signed 16-bit word.
   function [15:0] pvc_sat16;
      input signed [47:0] v;
      begin
         if (v > 48'sd32767) pvc_sat16 = 16'h7FFF;
         else if (v < -48'sd32768) pvc_sat16 = 16'h8000;
         else pvc_sat16 = v[15:0];
      end
   endfunction

   wire [17:0] fifo_dout;
   wire fifo_valid;
   reg [5:0] st_r;
   wire fifo_pop = st_r[0];

   // The FIFO absorbs bursts from the converter while a square root holds the pipeline.
   pvc_fifo #(.WIDTH(18), .DEPTH(32), .AW(5)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(samp_valid),
      .in_ready(samp_ready),
      .in_data({samp_ch, samp_data}),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_dout)
   );

   // Register file: configuration and sixteen parameter slots per channel.
   reg [17:0] cfg_r [0:3];
   reg [15:0] par_r [0:63];
   reg [15:0] pv_m [0:3];
   reg [15:0] rate_m [0:3];
   reg [7:0] stat_m [0:3];
   wire [1:0] a_ch = paddr[7:6];
   wire [3:0] a_idx = paddr[5:2] - 4'h1;
   wire [2:0] a_cls = pvc_dec(paddr);
   wire acc = psel & penable & ~pready_r;
   integer i;

   // One wait state: data and error are prepared in the first access cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
         for (i = 0; i < 64; i = i + 1) begin
            par_r[i] <= (i[3:0] == `PVC_P_SMAX) ? `PVC_RST_SMAX : (i[3:0] == `PVC_P_SPAN) ? `PVC_RST_SPAN : 16'h0000;
         end
         for (i = 0; i < 4; i = i + 1) begin
            cfg_r[i] <= `PVC_RST_CFG;
         end
      end else begin
         pready_r <= acc;
         pslverr_r <= acc & ((a_cls == 3'd7) | (pwrite & a_cls > 3'd1));
         prdata_r <= 32'h00000000;
         if (acc && !pwrite) begin
            case (a_cls)
               3'd0: prdata_r <= {14'h0000, cfg_r[a_ch]};
               3'd1: prdata_r <= {16'h0000, par_r[{a_ch, a_idx}]};
               3'd2: prdata_r <= {16'h0000, pv_m[a_ch]};
               3'd3: prdata_r <= {16'h0000, rate_m[a_ch]};
               3'd4: prdata_r <= {24'h000000, stat_m[a_ch]};
               default: prdata_r <= 32'h00000000;
            endcase
         end
         if (psel && penable && pready_r && pwrite) begin
            if (a_cls == 3'd0) begin
               cfg_r[a_ch] <= {(pwdata[17:12] > `PVC_MAX_DLY_S) ? `PVC_MAX_DLY_S : pwdata[17:12], pwdata[11:0]}; // [R7]
            end else if (a_cls == 3'd1) begin
               par_r[{a_ch, a_idx}] <= pwdata[15:0];
            end
         end
      end
   end

   // Wire-break pins cross into the clock domain through two flip-flops.
   reg [3:0] brk_m_r;
   reg [3:0] brk_s_r;
   reg [31:0] sec_cnt_r;
   reg [15:0] sec_r;
   wire [3:0] brk_done;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_m_r <= 4'h0;
         brk_s_r <= 4'h0;
         sec_cnt_r <= 32'h00000000;
         sec_r <= 16'h0000;
      end else begin
         brk_m_r <= wire_break;
         brk_s_r <= brk_m_r;
         sec_cnt_r <= (sec_cnt_r == SEC_CYC - 1) ? 32'h00000000 : sec_cnt_r + 32'h00000001;
         if (sec_cnt_r == SEC_CYC - 1) begin
            sec_r <= sec_r + 16'h0001;
         end
      end
   end

   // Each channel times how long its wire has been open.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_brk
         reg [31:0] bc_r;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               bc_r <= 32'h00000000;
            end else if (!brk_s_r[g]) begin
               bc_r <= 32'h00000000;
            end else if (bc_r != BREAK_CYC) begin
               bc_r <= bc_r + 32'h00000001; // [R4]
            end
         end
         assign brk_done[g] = (bc_r == BREAK_CYC);
      end
   endgenerate

   // Sample intake: disconnection substitution and range error check.
   wire [1:0] in_ch = fifo_dout[17:16];
   wire [2:0] in_rng = cfg_r[in_ch][`PVC_CFG_RANGE];
   wire in_lz = (in_rng == `PVC_RNG_4_20MA) || (in_rng == `PVC_RNG_1_5V);
   reg [15:0] x_in;
   always @* begin
      if (brk_s_r[in_ch] && !brk_done[in_ch]) x_in = `PVC_OVR_PV; // [R4]
      else if (brk_done[in_ch] && in_lz) x_in = `PVC_BREAK_PV; // [R2]
      else if (brk_done[in_ch]) x_in = (in_rng == `PVC_RNG_BIP10V) ? `PVC_MID_PV : 16'h0000; // [R3]
      else x_in = fifo_dout[15:0];
   end
   wire in_err = in_lz & (($signed({x_in[15], x_in}) < `PVC_ERR_LO) | ($signed({x_in[15], x_in}) > `PVC_ERR_HI)); // [R1]

   // Pipeline state of the sample in flight.
   reg [1:0] ch_r;
   reg [15:0] x_r;
   reg err_r;
   reg [15:0] avg_r;
   reg [15:0] res_r;
   reg [31:0] rad_r;
   reg [15:0] root_r;
   reg [4:0] bit_r;
   reg [15:0] hist_m [0:63];
   reg signed [20:0] sum_m [0:3];
   reg [4:0] cnt_m [0:3];
   reg [3:0] ptr_m [0:3];
   reg [3:0] nseen_m [0:3];
   reg [15:0] snap_m [0:3];
   reg [15:0] snapt_m [0:3];
   reg [5:0] act_m [0:3];
   reg [5:0] tm_m [0:3];
   reg [15:0] since_m [0:23];

   // Moving-average window update for the channel in flight.
   wire [17:0] c_cfg = cfg_r[ch_r];
   wire [4:0] n_avg = {1'b0, c_cfg[`PVC_CFG_NAVG]} + 5'd1;
   wire restart = (nseen_m[ch_r] != c_cfg[`PVC_CFG_NAVG]);
   wire win_full = (cnt_m[ch_r] == n_avg);
   reg signed [20:0] sum_n;
   reg [4:0] cnt_n;
   reg [3:0] wp_n;
   reg signed [38:0] avg_p;
   always @* begin
      if (restart) begin
         sum_n = {{5{x_r[15]}}, x_r}; // [R15]
         cnt_n = 5'd1;
         wp_n = 4'h0;
      end else begin
         sum_n = sum_m[ch_r] + {{5{x_r[15]}}, x_r} - (win_full ? {{5{hist_m[{ch_r, ptr_m[ch_r]}][15]}},
            hist_m[{ch_r, ptr_m[ch_r]}]} : 21'sd0); // [R5]
         cnt_n = win_full ? cnt_m[ch_r] : cnt_m[ch_r] + 5'd1;
         wp_n = ptr_m[ch_r];
      end
      avg_p = sum_n * $signed({1'b0, pvc_recip(cnt_n)});
   end

   // Scaling to user units, then zero and span adjustment.
   wire signed [16:0] s_a = $signed({par_r[{ch_r, `PVC_P_SMAX}][15], par_r[{ch_r, `PVC_P_SMAX}]});
   wire signed [16:0] s_b = $signed({par_r[{ch_r, `PVC_P_SMIN}][15], par_r[{ch_r, `PVC_P_SMIN}]});
   wire signed [16:0] s_ab = s_a - s_b;
   reg signed [47:0] scl_w;
   reg signed [47:0] adj_w;
   reg [15:0] adj_q;
   reg signed [47:0] over_b;
   always @* begin
      // Round to nearest so negative values do not floor one count low.
      scl_w = (s_ab * $signed({avg_r[15], avg_r}) * $signed({15'h0000, `PVC_RECIP_SPAN}) + 48'sh000080000000) >>> 32; // [R12]
      scl_w = scl_w + s_b;
      adj_w = ((scl_w * $signed({1'b0, par_r[{ch_r, `PVC_P_SPAN}]})) >>> 12) +
         $signed(par_r[{ch_r, `PVC_P_ZERO}]); // [R12]
      adj_q = pvc_sat16(adj_w);
      over_b = $signed({{32{adj_q[15]}}, adj_q}) - s_b;
   end
   wire root_go = c_cfg[`PVC_CFG_SQRT] && (s_a > s_b) && (over_b * 48'sd100 > `PVC_DROPOUT_PCT * s_ab); // [R10] [R14]
   wire [15:0] r_try = root_r | (16'h0001 << bit_r[3:0]);

   // Alarm conditions: four level alarms then rate high and low, all with the same band.
   wire signed [16:0] pv_s = $signed({res_r[15], res_r});
   wire signed [16:0] rate_s = pv_s - $signed({snap_m[ch_r][15], snap_m[ch_r]}); // [R13]
   wire signed [17:0] hys_s = $signed({2'b00, par_r[{ch_r, `PVC_P_HYS}]});
   wire [5:0] cond;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_al
         wire [3:0] pi = (g < 4) ? `PVC_P_AL0 + g : `PVC_P_RATE_H + g - 4;
         wire signed [17:0] thr = $signed({{2{par_r[{ch_r, pi}][15]}}, par_r[{ch_r, pi}]});
         wire signed [17:0] v = (g < 4) ? {pv_s[16], pv_s} : {rate_s[16], rate_s};
         wire hi = (g == 0) || (g == 1) || (g == 4);
         wire on = act_m[ch_r][g];
         assign cond[g] = hi ? (on ? v > thr - hys_s : v >= thr) : (on ? v < thr + hys_s : v <= thr); // [R6] [R8]
      end
   endgenerate
   wire [15:0] dly = {10'h000, c_cfg[`PVC_CFG_DLY]};
   wire [15:0] rivl = {12'h000, c_cfg[`PVC_CFG_RIVL]} + 16'h0001;
   integer k;

   // Sample sequencer; one sample at a time, under 30 cycles each, well inside the conversion period.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         ch_r <= 2'b00;
         x_r <= 16'h0000;
         err_r <= 1'b0;
         avg_r <= 16'h0000;
         res_r <= 16'h0000;
         rad_r <= 32'h00000000;
         root_r <= 16'h0000;
         bit_r <= 5'd0;
         out_valid_r <= 1'b0;
         out_ch_r <= 2'b00;
         out_pv_r <= 16'h0000;
         out_rate_r <= 16'h0000;
         out_alarm_r <= 6'h00;
         out_err_r <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            sum_m[i] <= 21'sd0;
            cnt_m[i] <= 5'd0;
            ptr_m[i] <= 4'h0;
            nseen_m[i] <= 4'h0;
            snap_m[i] <= 16'h0000;
            snapt_m[i] <= 16'h0000;
            act_m[i] <= 6'h00;
            tm_m[i] <= 6'h00;
            pv_m[i] <= 16'h0000;
            rate_m[i] <= 16'h0000;
            stat_m[i] <= 8'h00;
         end
         for (i = 0; i < 24; i = i + 1) begin
            since_m[i] <= 16'h0000;
         end
      end else begin
         out_valid_r <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (fifo_valid) begin
                  ch_r <= in_ch;
                  x_r <= x_in;
                  err_r <= in_err | brk_s_r[in_ch]; // [R1] [R4]
                  st_r <= S_AVG;
               end
            end
            S_AVG: begin
               hist_m[{ch_r, wp_n}] <= x_r; // [R5]
               ptr_m[ch_r] <= ({1'b0, wp_n} == n_avg - 5'd1) ? 4'h0 : wp_n + 4'h1;
               sum_m[ch_r] <= sum_n;
               cnt_m[ch_r] <= cnt_n;
               nseen_m[ch_r] <= c_cfg[`PVC_CFG_NAVG]; // [R15]
               avg_r <= avg_p[31:16];
               st_r <= S_SCALE;
            end
            S_SCALE: begin
               res_r <= adj_q;
               rad_r <= s_ab[15:0] * over_b[15:0]; // [R9]
               root_r <= 16'h0000;
               bit_r <= 5'd15;
               st_r <= root_go ? S_ROOT : S_ALARM; // [R10] [R14]
            end
            S_ROOT: begin
               // Bit-serial integer root: one result bit per cycle, no divider needed.
               if ({16'h0000, r_try} * {16'h0000, r_try} <= {32'h00000000, rad_r}) begin
                  root_r <= r_try;
               end
               bit_r <= bit_r - 5'd1;
               if (bit_r == 5'd0) begin
                  st_r <= S_OUT;
               end
            end
            S_OUT: begin
               res_r <= pvc_sat16($signed({{32{root_r[15] & 1'b0}}, root_r}) + s_b); // [R9] [R12]
               st_r <= S_ALARM;
            end
            S_ALARM: begin
               if (sec_r - snapt_m[ch_r] >= rivl) begin
                  snap_m[ch_r] <= res_r; // [R13]
                  snapt_m[ch_r] <= sec_r;
               end
               for (k = 0; k < 6; k = k + 1) begin
                  if (!cond[k]) begin
                     act_m[ch_r][k] <= 1'b0;
                     tm_m[ch_r][k] <= 1'b0;
                  end else if (!act_m[ch_r][k] && !tm_m[ch_r][k]) begin
                     tm_m[ch_r][k] <= 1'b1;
                     since_m[ch_r * 6 + k] <= sec_r;
                     act_m[ch_r][k] <= (dly == 16'h0000); // [R7]
                  end else if (!act_m[ch_r][k] && (sec_r - since_m[ch_r * 6 + k] >= dly)) begin
                     act_m[ch_r][k] <= 1'b1; // [R7] [R8]
                  end
               end
               pv_m[ch_r] <= res_r; // [R11] [R12]
               rate_m[ch_r] <= rate_s[15:0];
               stat_m[ch_r] <= {brk_done[ch_r], err_r, act_m[ch_r]};
               out_valid_r <= 1'b1; // [R11]
               out_ch_r <= ch_r;
               out_pv_r <= res_r;
               out_rate_r <= rate_s[15:0];
               out_alarm_r <= act_m[ch_r];
               out_err_r <= err_r;
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // pvc_top

// File: dv/pvc_chk_sva.sv
// Assertion checker bound to the process value conditioning top ports.
`timescale 1ns/1ps
module pvc_chk #(
   parameter SEC_CYC = 20,
   parameter BREAK_CYC = 60
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata_r,
   input wire pready_r,
   input wire pslverr_r,
   input wire samp_valid,
   input wire samp_ready,
   input wire out_valid_r,
   input wire [1:0] out_ch_r,
   input wire [15:0] out_pv_r,
   input wire [15:0] out_rate_r,
   input wire [5:0] out_alarm_r,
   input wire out_err_r
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // One wait state, then a one-cycle answer.
   apb_wait_a: assert property (psel && penable && !pready_r |=> pready_r) else $error("no answer after one wait");
   ready_pulse_a: assert property (pready_r |=> !pready_r) else $error("ready held too long");
   rdata_idle_a: assert property (!pready_r |-> prdata_r == 32'h0) else $error("read data outside answer");
   err_ready_a: assert property (pslverr_r |-> pready_r) else $error("error without ready");
   // Result words are read-only.
   ro_write_a: assert property (psel && penable && pready_r && pwrite && paddr[5:4] == 2'h3 |-> pslverr_r)
      else $error("write to result word accepted");
   // Each result appears once and then stands until the next one.
   out_pulse_a: assert property (out_valid_r |=> !out_valid_r) else $error("result pulse too long");
   out_hold_a: assert property (!out_valid_r |-> $stable({out_ch_r, out_pv_r, out_rate_r, out_alarm_r, out_err_r}))
      else $error("result changed between pulses");
   // Every accepted sample leads to a result within the deepest backlog.
   out_bound_a: assert property (samp_valid && samp_ready |-> ##[1:800] out_valid_r) else $error("sample lost");
   fifo_fall_a: assert property ($fell(samp_ready) |-> $past(samp_valid)) else $error("ready fell without push");
endmodule // pvc_chk
bind pvc_top pvc_chk #(.SEC_CYC(SEC_CYC), .BREAK_CYC(BREAK_CYC)) pvc_chk_i (.*);

// File: dv/pvc_host.sv
// Host model that copies each processed result off the output port.
`timescale 1ns/1ps
module pvc_host (
   input wire pclk,
   input wire presetn,
   input wire out_valid_r,
   input wire [15:0] out_pv_r,
   input wire [5:0] out_alarm_r,
   input wire out_err_r
);
   reg [15:0] pv_r;
   reg [5:0] alarm_r;
   reg err_r;
   integer n_out;
   // Copies each result in its pulse cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_out <= 0;
         pv_r <= 16'h0000;
         alarm_r <= 6'h00;
         err_r <= 1'b0;
      end else if (out_valid_r) begin
         n_out <= n_out + 1;
         pv_r <= out_pv_r;
         alarm_r <= out_alarm_r;
         err_r <= out_err_r;
      end
   end
endmodule // pvc_host

// File: dv/testbench.sv
// Self-checking bench for the process value conditioning block.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
   $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s); end end
module testbench;
   localparam SEC = 20;
   localparam BRK = 60;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, samp_valid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] samp_ch = 2'h0;
   logic [15:0] samp_data = 16'h0000;
   logic [3:0] wire_break = 4'h0;
   wire [31:0] prdata_r;
   wire pready_r, pslverr_r, samp_ready, out_valid_r, out_err_r;
   wire [1:0] out_ch_r;
   wire [15:0] out_pv_r, out_rate_r;
   wire [5:0] out_alarm_r;
   logic [31:0] rd;
   logic er;
   integer fails = 0, n_tests = 0;

   pvc_top #(.SEC_CYC(SEC), .BREAK_CYC(BRK)) pvc_top_i (.*);
   pvc_host pvc_host_i (.*);

   // The clock toggles every half period of 4 ns.
   always #4 pclk = ~pclk;

   function automatic [11:0] ad(input [1:0] c, input [5:0] o);
      ad = {4'h0, c, o};
   endfunction

   // One bus transfer; the request stands until ready is seen high at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready_r !== 1'b1 && k < 40);
      if (k >= 40) fails++;
      rd = prdata_r;
      er = pslverr_r;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Pushes one sample and waits until its result has reached the host.
   task automatic send(input logic [1:0] c, input logic [15:0] d);
      integer k, n0;
      n0 = pvc_host_i.n_out;
      k = 0;
      @(posedge pclk);
      samp_valid <= 1'b1; samp_ch <= c; samp_data <= d;
      do begin @(posedge pclk); k++; end while (samp_ready !== 1'b1 && k < 100);
      samp_valid <= 1'b0;
      do begin @(posedge pclk); k++; end while (pvc_host_i.n_out == n0 && k < 200);
      if (k >= 200) fails++;
   endtask

   task automatic t_regs;
      apb(1'b0, ad(2'h0, 6'h00), 32'h0);
      `CHK("cfg_rst", 32'h0, rd)
      apb(1'b0, ad(2'h3, 6'h04), 32'h0);
      `CHK("smax_rst", 32'h2710, rd)
      apb(1'b0, ad(2'h1, 6'h10), 32'h0);
      `CHK("span_rst", 32'h1000, rd)
      wr(ad(2'h0, 6'h30), 32'h1234);
      `CHK("pv_ro", 1'b1, er)
      apb(1'b0, ad(2'h2, 6'h3C), 32'h0);
      `CHK("unmapped", 1'b1, er)
      $display("regs done");
   endtask

   task automatic t_avg;
      wr(ad(2'h0, 6'h00), 32'h5);
      send(2'h0, 16'h2328);
      `CHK("avg_one", 16'h2328, pvc_host_i.pv_r)
      wr(ad(2'h0, 6'h00), 32'h15);
      send(2'h0, 16'h03E8);
      `CHK("restart", 1'b1, pvc_host_i.pv_r !== 16'h1388)
      send(2'h0, 16'h0BB8);
      `CHK("avg_two", 1'b1, pvc_host_i.pv_r >= 16'h07CF && pvc_host_i.pv_r <= 16'h07D0)
      $display("avg done");
   endtask

   // Limits at both edges, for the live-zero ranges and two unchecked ranges.
   task automatic t_err;
      logic [15:0] v [0:5];
      logic [2:0] r [0:5];
      logic e [0:5];
      v = '{16'hF947, 16'hF948, 16'h2BF2, 16'h2BF3, 16'h2BF3, 16'hF947};
      r = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h4, 3'h5};
      e = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++) begin
         wr(ad(2'h1, 6'h00), {29'h0, r[i]});
         send(2'h1, v[i]);
         `CHK("range_err", e[i], pvc_host_i.err_r)
      end
      $display("err done");
   endtask

   task automatic t_break;
      wr(ad(2'h1, 6'h00), 32'h0);
      wr(ad(2'h2, 6'h00), 32'h5);
      wr(ad(2'h3, 6'h00), 32'h2);
      wire_break <= 4'hE;
      repeat (3) @(posedge pclk);
      send(2'h1, 16'h07D0);
      `CHK("over_pv", 16'h2CEC, pvc_host_i.pv_r)
      `CHK("over_err", 1'b1, pvc_host_i.err_r)
      repeat (BRK) @(posedge pclk);
      send(2'h1, 16'h07D0);
      `CHK("brk_live", 16'hFA24, pvc_host_i.pv_r)
      send(2'h2, 16'h07D0);
      `CHK("brk_bip", 16'h1388, pvc_host_i.pv_r)
      send(2'h3, 16'h07D0);
      `CHK("brk_zero", 16'h0000, pvc_host_i.pv_r)
      wire_break <= 4'h0;
      repeat (4) @(posedge pclk);
      send(2'h1, 16'h07D0);
      `CHK("brk_gone", 16'h07D0, pvc_host_i.pv_r)
      $display("break done");
   endtask

   task automatic t_sqrt;
      wr(ad(2'h0, 6'h00), 32'hD);
      send(2'h0, 16'h09C4);
      `CHK("root", 16'h1388, pvc_host_i.pv_r)
      send(2'h0, 16'h01F4);
      `CHK("dropout", 16'h01F4, pvc_host_i.pv_r)
      wr(ad(2'h0, 6'h04), 32'h0);
      wr(ad(2'h0, 6'h08), 32'h2710);
      send(2'h0, 16'h09C4);
      `CHK("no_root", 16'h1D4C, pvc_host_i.pv_r)
      wr(ad(2'h0, 6'h04), 32'h2710);
      wr(ad(2'h0, 6'h08), 32'h0);
      wr(ad(2'h0, 6'h00), 32'h5);
      $display("sqrt done");
   endtask

   // The result carries the alarm state from before its own sample.
   task automatic t_alarm;
      logic [15:0] th [0:6];
      th = '{16'h1F40, 16'h1770, 16'hEC78, 16'hE0C0, 16'h01F4, 16'h7FFF, 16'h8000};
      for (int i = 0; i < 7; i++) wr(ad(2'h2, 6'h14 + 6'(4 * i)), {16'h0, th[i]});
      wr(ad(2'h2, 6'h00), 32'h5);
      send(2'h2, 16'h2328);
      send(2'h2, 16'h2328);
      `CHK("high_set", 6'h03, pvc_host_i.alarm_r)
      send(2'h2, 16'h1E78);
      send(2'h2, 16'h0000);
      `CHK("hys_hold", 6'h03, pvc_host_i.alarm_r)
      send(2'h2, 16'h0000);
      `CHK("released", 6'h00, pvc_host_i.alarm_r)
      send(2'h2, 16'hDCD8);
      send(2'h2, 16'hDCD8);
      `CHK("low_set", 6'h0C, pvc_host_i.alarm_r)
      wr(ad(2'h2, 6'h00), 32'h2005);
      send(2'h2, 16'h0000);
      send(2'h2, 16'h0000);
      repeat (3) send(2'h2, 16'h2328);
      `CHK("delay_wait", 6'h00, pvc_host_i.alarm_r)
      repeat (3 * SEC) @(posedge pclk);
      repeat (2) send(2'h2, 16'h2328);
      `CHK("delay_set", 6'h03, pvc_host_i.alarm_r)
      $display("alarm done");
   endtask

   // Long interval: the second sample's rate is measured from the first.
   task automatic t_rate;
      wr(ad(2'h3, 6'h28), 32'h7D0);
      wr(ad(2'h3, 6'h00), 32'hF02);
      repeat (17 * SEC) @(posedge pclk);
      send(2'h3, 16'h03E8);
      send(2'h3, 16'h0BB8);
      `CHK("rate", 16'h07D0, out_rate_r)
      `CHK("rate_ch", 2'h3, out_ch_r)
      send(2'h3, 16'h0BB8);
      `CHK("rate_al", 6'h13, pvc_host_i.alarm_r)
      $display("rate done");
   endtask

   // Holds valid high for 48 cycles so the buffer fills and refuses, then lets it drain.
   task automatic t_fifo;
      integer k, n0, acc, refused;
      n0 = pvc_host_i.n_out;
      acc = 0;
      refused = 0;
      @(posedge pclk);
      samp_valid <= 1'b1; samp_ch <= 2'h0; samp_data <= 16'h0064;
      for (k = 0; k < 48; k++) begin
         @(posedge pclk);
         if (samp_ready === 1'b1) acc++; else refused++;
      end
      samp_valid <= 1'b0;
      k = 0;
      while (pvc_host_i.n_out - n0 < acc && k < 2000) begin @(posedge pclk); k++; end
      `CHK("full", 1'b1, refused > 0)
      `CHK("drained", acc, pvc_host_i.n_out - n0)
      `CHK("empty", 1'b1, samp_ready)
      $display("fifo done");
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs; t_avg; t_err; t_break; t_sqrt; t_alarm; t_rate; t_fifo;
      report_and_stop;
   end

   // A hang counts as a mismatch and ends the run the same way.
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      report_and_stop;
   end
endmodule // testbench
